// ===== hdl/pin_mux_pkg.sv
// constants, field layouts and carrier types of the gpio pin mux slice
// assumes one 25 mhz clock domain and a plain strobe register port
package pin_mux_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [31:0] P4_CFG_ADDR = 32'hfff83040;
  localparam logic [31:0] P4_DIR_ADDR = 32'hfff83044;
  localparam logic [31:0] P4_OUT_ADDR = 32'hfff83048;
  localparam logic [31:0] P4_IN_ADDR = 32'hfff8304c;
  localparam logic [31:0] P5_SEL_ADDR = 32'hfff83050;

  // ==========================================================
  // field positions and widths
  localparam int P4_BIT = 10;
  localparam int P4_CFG_LSB = 20;
  localparam int FIELD_W = 2;
  localparam int P5_PINS = 13;
  localparam int P5_SEL_W = 26;
  localparam int ALT_SEL_LO = 1;
  localparam int ALT_SEL_HI = 3;

  // ==========================================================
  // reset values
  localparam logic [1:0] P4_CFG_RESET = 2'h1;
  localparam logic P4_DIR_RESET = 1'b0;
  localparam logic P4_OUT_RESET = 1'b0;
  localparam logic [P5_SEL_W-1:0] P5_SEL_RESET = 26'h0000000;
  localparam logic [31:0] RD_IDLE = 32'h00000000;
  localparam logic ALT_IDLE = 1'b1;

  // ==========================================================
  // function select codes
  localparam logic [1:0] SEL_GPIO = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;
  localparam logic [1:0] SEL_ALT3 = 2'h3;

  // pad behaviour of one selected function
  typedef enum logic [1:0]
  {
    KIND_NONE = 2'h0,
    KIND_IN = 2'h1,
    KIND_OUT = 2'h2,
    KIND_IO = 2'h3
  } pin_kind_type;

  // ==========================================================
  // carriers
  typedef struct packed
  {
    logic [31:0] addr;
    logic [31:0] wrData;
    logic wrStb;
    logic rdStb;
  } reg_req_type;

  // peripheral levels and drive enables, per pin and alt code 1..3
  typedef struct packed
  {
    logic [P5_PINS-1:0][ALT_SEL_HI:ALT_SEL_LO] level;
    logic [P5_PINS-1:0][ALT_SEL_HI:ALT_SEL_LO] drive;
  } alt_src_type;

  // port 5 gpio data and output enable from the gpio core
  typedef struct packed
  {
    logic [P5_PINS-1:0] out;
    logic [P5_PINS-1:0] outEn;
  } gpio_drive_type;

endpackage : pin_mux_pkg

// ===== hdl/gpio_pin_mux.sv
// port 4 data registers and port 5 pin function multiplexer
// assumes pins arrive asynchronously, peripherals and the gpio core share
// sys_clk, and the pad ring resolves out/oe_n into real pads

// Behaviour
// RULE1 - port 4 pin drives stored output bit
// RULE2 - only bit 10 stored, other writes ignored
// RULE3 - port 4 output data resets to zero
// RULE4 - input bit 10 shows live pin level
// RULE5 - unused input data bits read zero
// RULE6 - input data has no reset value
// RULE7 - thirteen two-bit select fields, reset zero
// RULE8 - code 00 gives plain bidirectional gpio
// RULE9 - pins 0-3 code 01 uart functions
// RULE10 - pin 4: uart2 tx, cts, ps2 clock
// RULE11 - pin 5: uart2 rx, rts, ps2 data
// RULE12 - pins 6-7: i2c a, sync serial, timers
// RULE13 - pins 8-9: i2c b, sync serial, keypad
// RULE14 - pin 10: watchdog or usb power enable
// RULE15 - pins 11-12: interrupts, usb overcurrent input
// RULE16 - port 4 drives only when enabled and gpio
// RULE17 - software avoids reserved select codes
module gpio_pin_mux
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire pin_mux_pkg::reg_req_type regReq,
  output logic [31:0] rdData_ff,
  input wire logic port4PinIn,
  output logic port4PinOut_ff,
  output logic port4PinOeN_ff,
  input wire logic [pin_mux_pkg::P5_PINS-1:0] port5PinIn,
  output logic [pin_mux_pkg::P5_PINS-1:0] port5PinOut_ff,
  output logic [pin_mux_pkg::P5_PINS-1:0] port5PinOeN_ff,
  input wire pin_mux_pkg::gpio_drive_type gpio5Drive,
  output logic [pin_mux_pkg::P5_PINS-1:0] gpio5In_ff,
  input wire pin_mux_pkg::alt_src_type altSrc,
  output logic [pin_mux_pkg::P5_PINS-1:0]
    [pin_mux_pkg::ALT_SEL_HI:pin_mux_pkg::ALT_SEL_LO] altIn_ff
);

  // ==========================================================
  // pad kind of each port 5 pin and select code
  function automatic pin_mux_pkg::pin_kind_type pinKind
  (
    input int pin,
    input logic [1:0] sel
  );
    pin_mux_pkg::pin_kind_type kind;
    kind = pin_mux_pkg::KIND_NONE;
    if (sel == pin_mux_pkg::SEL_GPIO)
    begin
      kind = pin_mux_pkg::KIND_IO; // [RULE8]
    end
    else
    begin
      unique case (pin)
        // output, uart0 rx, uart1 tx, uart1 rx; upper codes reserved
        0, 2: kind = (sel == pin_mux_pkg::SEL_ALT1) ?
          pin_mux_pkg::KIND_OUT : pin_mux_pkg::KIND_NONE; // [RULE9]
        1, 3: kind = (sel == pin_mux_pkg::SEL_ALT1) ?
          pin_mux_pkg::KIND_IN : pin_mux_pkg::KIND_NONE; // [RULE9]
        // uart2 tx, uart1 cts in, ps2 clock out
        4: kind = (sel == pin_mux_pkg::SEL_ALT2) ?
          pin_mux_pkg::KIND_IN : pin_mux_pkg::KIND_OUT; // [RULE10]
        // uart2 rx in, uart1 rts out, ps2 data both ways
        5:
        begin
          unique case (sel)
            pin_mux_pkg::SEL_ALT1: kind = pin_mux_pkg::KIND_IN; // [RULE11]
            pin_mux_pkg::SEL_ALT2: kind = pin_mux_pkg::KIND_OUT; // [RULE11]
            default: kind = pin_mux_pkg::KIND_IO; // [RULE11]
          endcase
        end
        // i2c a, sync serial frame/tx, timer outputs
        6, 7: kind = (sel == pin_mux_pkg::SEL_ALT1) ?
          pin_mux_pkg::KIND_IO : pin_mux_pkg::KIND_OUT; // [RULE12]
        // i2c b, sync serial clock, keypad row
        8: kind = (sel == pin_mux_pkg::SEL_ALT1) ?
          pin_mux_pkg::KIND_IO : pin_mux_pkg::KIND_OUT; // [RULE13]
        // i2c b data, sync serial receive, keypad row
        9:
        begin
          unique case (sel)
            pin_mux_pkg::SEL_ALT1: kind = pin_mux_pkg::KIND_IO; // [RULE13]
            pin_mux_pkg::SEL_ALT2: kind = pin_mux_pkg::KIND_IN; // [RULE13]
            default: kind = pin_mux_pkg::KIND_OUT; // [RULE13]
          endcase
        end
        // watchdog, usb power enable; top code reserved
        10: kind = (sel == pin_mux_pkg::SEL_ALT3) ?
          pin_mux_pkg::KIND_NONE : pin_mux_pkg::KIND_OUT; // [RULE14]
        // interrupt a only
        11: kind = (sel == pin_mux_pkg::SEL_ALT1) ?
          pin_mux_pkg::KIND_IN : pin_mux_pkg::KIND_NONE; // [RULE15]
        // interrupt b, usb overcurrent
        12: kind = (sel == pin_mux_pkg::SEL_ALT3) ?
          pin_mux_pkg::KIND_NONE : pin_mux_pkg::KIND_IN; // [RULE15]
        default: kind = pin_mux_pkg::KIND_NONE;
      endcase
    end
    return kind;
  endfunction : pinKind

  // ==========================================================
  // register access decode
  logic wrCfg4;
  logic wrDir4;
  logic wrOut4;
  logic wrSel5;

  assign wrCfg4 = regReq.wrStb && (regReq.addr == pin_mux_pkg::P4_CFG_ADDR);
  assign wrDir4 = regReq.wrStb && (regReq.addr == pin_mux_pkg::P4_DIR_ADDR);
  assign wrOut4 = regReq.wrStb && (regReq.addr == pin_mux_pkg::P4_OUT_ADDR);
  assign wrSel5 = regReq.wrStb && (regReq.addr == pin_mux_pkg::P5_SEL_ADDR);

  // ==========================================================
  // software registers
  logic [1:0] port4Function_ff;
  logic port4_output_enable_ff;
  logic port4_out_bit_ff;
  logic [pin_mux_pkg::P5_SEL_W-1:0] port5_function_select_ff;

  // port 4 function field, resets to a non-gpio function
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      port4Function_ff <= pin_mux_pkg::P4_CFG_RESET;
    else if (wrCfg4)
      port4Function_ff <=
        regReq.wrData[pin_mux_pkg::P4_CFG_LSB +: pin_mux_pkg::FIELD_W];
  end

  // port 4 output enable
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      port4_output_enable_ff <= pin_mux_pkg::P4_DIR_RESET;
    else if (wrDir4)
      port4_output_enable_ff <= regReq.wrData[pin_mux_pkg::P4_BIT];
  end

  // port 4 output data: one stored bit, the rest of the word dropped
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      port4_out_bit_ff <= pin_mux_pkg::P4_OUT_RESET; // [RULE3]
    else if (wrOut4)
      port4_out_bit_ff <= regReq.wrData[pin_mux_pkg::P4_BIT]; // [RULE2]
  end

  // port 5 select fields; bits 31:26 are not stored
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      port5_function_select_ff <= pin_mux_pkg::P5_SEL_RESET; // [RULE7]
    else if (wrSel5)
      port5_function_select_ff <=
        regReq.wrData[pin_mux_pkg::P5_SEL_W-1:0]; // [RULE7]
  end

  // ==========================================================
  // pin synchronisers; stage one feeds only stage two
  logic port4Meta_ff;
  logic port4Sync_ff;
  logic [pin_mux_pkg::P5_PINS-1:0] port5Meta_ff;
  logic [pin_mux_pkg::P5_PINS-1:0] port5Sync_ff;

  // no reset value needed in spirit, but keep outputs defined
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port4Meta_ff <= 1'b0;
      port4Sync_ff <= 1'b0;
      port5Meta_ff <= '0;
      port5Sync_ff <= '0;
    end
    else
    begin
      port4Meta_ff <= port4PinIn;
      port4Sync_ff <= port4Meta_ff;
      port5Meta_ff <= port5PinIn;
      port5Sync_ff <= port5Meta_ff;
    end
  end

  // ==========================================================
  // register read port, data valid only in the cycle after the strobe
  logic [31:0] nxt_rdData;

  always_comb
  begin
    nxt_rdData = pin_mux_pkg::RD_IDLE;
    if (regReq.rdStb)
    begin
      unique case (regReq.addr)
        pin_mux_pkg::P4_CFG_ADDR:
          nxt_rdData[pin_mux_pkg::P4_CFG_LSB +: pin_mux_pkg::FIELD_W] =
            port4Function_ff;
        pin_mux_pkg::P4_DIR_ADDR:
          nxt_rdData[pin_mux_pkg::P4_BIT] = port4_output_enable_ff;
        pin_mux_pkg::P4_OUT_ADDR:
          nxt_rdData[pin_mux_pkg::P4_BIT] = port4_out_bit_ff;
        // live pin level whatever the mode; other bits stay zero
        pin_mux_pkg::P4_IN_ADDR:
          nxt_rdData[pin_mux_pkg::P4_BIT] = port4Sync_ff; // [RULE4] [RULE5]
        pin_mux_pkg::P5_SEL_ADDR:
          nxt_rdData[pin_mux_pkg::P5_SEL_W-1:0] = port5_function_select_ff;
        default:
          nxt_rdData = pin_mux_pkg::RD_IDLE; // unmapped reads as zero
      endcase
    end
  end

  // input data follows the pin; the reset zero is only the sync flops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdData_ff <= pin_mux_pkg::RD_IDLE; // [RULE6]
    else
      rdData_ff <= nxt_rdData;
  end

  // ==========================================================
  // port 4 pad: driven only in gpio mode with the enable set
  logic port4Drive;

  assign port4Drive = port4_output_enable_ff &&
    (port4Function_ff == pin_mux_pkg::SEL_GPIO); // [RULE16]

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port4PinOut_ff <= pin_mux_pkg::P4_OUT_RESET;
      port4PinOeN_ff <= 1'b1;
    end
    else
    begin
      port4PinOut_ff <= port4_out_bit_ff; // [RULE1]
      port4PinOeN_ff <= !port4Drive; // [RULE1] [RULE16]
    end
  end

  // ==========================================================
  // port 5 pad multiplexer, one slice per pin
  logic [pin_mux_pkg::P5_PINS-1:0] nxt_port5Out;
  logic [pin_mux_pkg::P5_PINS-1:0] nxt_port5OeN;
  logic [pin_mux_pkg::P5_PINS-1:0]
    [pin_mux_pkg::ALT_SEL_HI:pin_mux_pkg::ALT_SEL_LO] nxt_altIn;

  genvar gp;
  genvar gs;
  generate
    for (gp = 0; gp < pin_mux_pkg::P5_PINS; gp++)
    begin : g_pin
      logic [1:0] sel;
      pin_mux_pkg::pin_kind_type kind;

      assign sel = port5_function_select_ff[gp*pin_mux_pkg::FIELD_W +:
        pin_mux_pkg::FIELD_W]; // [RULE7]
      assign kind = pinKind(gp, sel);

      // reserved codes leave the pad floating, the safest guess
      always_comb
      begin
        nxt_port5Out[gp] = 1'b0;
        nxt_port5OeN[gp] = 1'b1;
        if (sel == pin_mux_pkg::SEL_GPIO)
        begin
          nxt_port5Out[gp] = gpio5Drive.out[gp]; // [RULE8]
          nxt_port5OeN[gp] = !gpio5Drive.outEn[gp]; // [RULE8]
        end
        else
        begin
          nxt_port5Out[gp] = altSrc.level[gp][sel];
          unique case (kind)
            pin_mux_pkg::KIND_OUT: nxt_port5OeN[gp] = 1'b0;
            pin_mux_pkg::KIND_IO:
              nxt_port5OeN[gp] = !altSrc.drive[gp][sel];
            pin_mux_pkg::KIND_IN: nxt_port5OeN[gp] = 1'b1;
            pin_mux_pkg::KIND_NONE: nxt_port5OeN[gp] = 1'b1; // [RULE17]
          endcase
        end
      end

      // unselected peripheral inputs idle high so active-low
      // interrupts and open-drain lines see no false edge
      for (gs = pin_mux_pkg::ALT_SEL_LO; gs <= pin_mux_pkg::ALT_SEL_HI;
        gs++)
      begin : g_alt
        assign nxt_altIn[gp][gs] =
          ((sel == 2'(gs)) && ((kind == pin_mux_pkg::KIND_IN) ||
          (kind == pin_mux_pkg::KIND_IO))) ?
          port5Sync_ff[gp] : pin_mux_pkg::ALT_IDLE;
      end
    end
  endgenerate

  // registered pad drive, peripheral inputs and gpio input levels
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port5PinOut_ff <= '0;
      port5PinOeN_ff <= '1;
      altIn_ff <= '1;
      gpio5In_ff <= '0;
    end
    else
    begin
      port5PinOut_ff <= nxt_port5Out;
      port5PinOeN_ff <= nxt_port5OeN;
      altIn_ff <= nxt_altIn;
      gpio5In_ff <= port5Sync_ff;
    end
  end

endmodule : gpio_pin_mux

// ===== bench/pin_mux_assertions.sv
// checker: register readback and pad rules of the pin mux
// assumes it is bound to gpio_pin_mux and mirrors register writes itself
module pin_mux_assertions
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire pin_mux_pkg::reg_req_type regReq,
  input wire logic [31:0] rdData_ff,
  input wire logic port4PinIn,
  input wire logic port4PinOut_ff,
  input wire logic port4PinOeN_ff,
  input wire logic [12:0] port5PinIn,
  input wire logic [12:0] port5PinOut_ff,
  input wire logic [12:0] port5PinOeN_ff,
  input wire pin_mux_pkg::gpio_drive_type gpio5Drive,
  input wire logic [12:0] gpio5In_ff,
  input wire pin_mux_pkg::alt_src_type altSrc,
  input wire logic [12:0][3:1] altIn_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CFG = pin_mux_pkg::P4_CFG_ADDR;
  localparam logic [31:0] A_DIR = pin_mux_pkg::P4_DIR_ADDR;
  localparam logic [31:0] A_OUT = pin_mux_pkg::P4_OUT_ADDR;
  localparam logic [31:0] A_IN = pin_mux_pkg::P4_IN_ADDR;
  localparam logic [31:0] A_SEL = pin_mux_pkg::P5_SEL_ADDR;
  logic [1:0] cfgSh_ff;
  logic dirSh_ff;
  logic outSh_ff;
  logic [25:0] selSh_ff;
  logic p4Gate;
  logic [12:0] gpioMask;

  // ==========================================================
  // mirror of stored fields; unmapped writes never reach it
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      cfgSh_ff <= 2'h1;
      dirSh_ff <= 1'b0;
      outSh_ff <= 1'b0;
      selSh_ff <= 26'h0;
    end
    else if (regReq.wrStb)
    begin
      if (regReq.addr == A_CFG) cfgSh_ff <= regReq.wrData[21:20];
      if (regReq.addr == A_DIR) dirSh_ff <= regReq.wrData[10];
      if (regReq.addr == A_OUT) outSh_ff <= regReq.wrData[10];
      if (regReq.addr == A_SEL) selSh_ff <= regReq.wrData[25:0];
    end

  // enable counts only in gpio mode
  assign p4Gate = cfgSh_ff == 2'h0 && dirSh_ff;
  always_comb
    for (int i = 0; i < 13; i++)
      gpioMask[i] = selSh_ff[2*i+:2] == 2'h0;

  // ==========================================================
  // properties
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_sel_readback: assert property (
    regReq.rdStb && regReq.addr == A_SEL
    |=> rdData_ff == {6'h0, $past(selSh_ff)}) else $error("select read");
  chk_out_readback: assert property (
    regReq.rdStb && regReq.addr == A_OUT
    |=> rdData_ff == {21'h0, $past(outSh_ff), 10'h0}) else $error("out read");
  chk_in_live_level: assert property (
    regReq.rdStb && regReq.addr == A_IN && $past(rst_b, 4) &&
    $past(port4PinIn, 3) == port4PinIn && $stable(port4PinIn) &&
    $past(port4PinIn, 2) == port4PinIn
    |=> rdData_ff == {21'h0, $past(port4PinIn), 10'h0}) else $error("in read");
  chk_p4_enable_gate: assert property (
    port4PinOeN_ff == !$past(p4Gate)) else $error("port 4 enable");
  chk_p4_out_value: assert property (
    !port4PinOeN_ff |-> port4PinOut_ff == $past(outSh_ff))
    else $error("port 4 level");
  chk_gpio_enable: assert property (
    $past(rst_b) |-> ((port5PinOeN_ff ^ ~$past(gpio5Drive.outEn))
    & $past(gpioMask)) == 13'h0) else $error("gpio enable");
  chk_gpio_level: assert property (
    $past(rst_b) |-> ((port5PinOut_ff ^ $past(gpio5Drive.out))
    & $past(gpioMask)) == 13'h0) else $error("gpio level");
  chk_reserved_float: assert property (
    $past(selSh_ff[23:22]) > 2'h1 |-> port5PinOeN_ff[11])
    else $error("reserved code drives");
  chk_i2c_drive: assert property (
    $past(selSh_ff[13:12]) == 2'h1
    |-> port5PinOeN_ff[6] == !$past(altSrc.drive[6][1]))
    else $error("i2c drive");
endmodule : pin_mux_assertions

bind gpio_pin_mux pin_mux_assertions u_pin_mux_assertions (.sys_clk, .rst_b,
  .regReq, .rdData_ff, .port4PinIn, .port4PinOut_ff, .port4PinOeN_ff,
  .port5PinIn, .port5PinOut_ff, .port5PinOeN_ff, .gpio5Drive, .gpio5In_ff,
  .altSrc, .altIn_ff);

// ===== bench/pad_model.sv
// board side of the pads: a driven pad shows the device level
// assumes active low enables and no pull resistors on the board
module pad_model
(
  input wire logic p4Out,
  input wire logic p4OeN,
  input wire logic [12:0] p5Out,
  input wire logic [12:0] p5OeN,
  input wire logic p4Board,
  input wire logic [12:0] p5Board,
  output logic p4Level,
  output logic [12:0] p5Level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // the board only wins where the device lets the pad float
  assign p4Level = p4OeN ? p4Board : p4Out;
  assign p5Level = (p5OeN & p5Board) | (~p5OeN & p5Out);
endmodule : pad_model

// ===== bench/testbench.sv
// bench for the pin mux: register port, port 4 pad, port 5 functions
// assumes the design package, the pad model and the bound checker
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CFG = pin_mux_pkg::P4_CFG_ADDR;
  localparam logic [31:0] A_DIR = pin_mux_pkg::P4_DIR_ADDR;
  localparam logic [31:0] A_OUT = pin_mux_pkg::P4_OUT_ADDR;
  localparam logic [31:0] A_IN = pin_mux_pkg::P4_IN_ADDR;
  localparam logic [31:0] A_SEL = pin_mux_pkg::P5_SEL_ADDR;
  // per pin, codes 1..3: O drives, I listens, - reserved
  localparam string KIND =
    "O--.I--.O--.I--.OIO.IOO.OOO.OOO.OOO.OIO.OO-.I--.II-";
  // gpio core data pattern; each pin's expected level is its own bit
  localparam logic [12:0] GPIO_OUT = 13'h0a5a;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  pin_mux_pkg::reg_req_type regReq = '0;
  pin_mux_pkg::gpio_drive_type gpio5Drive = '0;
  pin_mux_pkg::alt_src_type altSrc = '0;
  logic [31:0] rdData_ff;
  logic port4PinIn, port4PinOut_ff, port4PinOeN_ff;
  logic [12:0] port5PinIn, port5PinOut_ff, port5PinOeN_ff, gpio5In_ff;
  logic [12:0][3:1] altIn_ff;
  logic p4Board = 1'b0;
  logic [12:0] p5Board = 13'h0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  gpio_pin_mux u_gpio_pin_mux (.sys_clk, .rst_b, .regReq, .rdData_ff,
    .port4PinIn, .port4PinOut_ff, .port4PinOeN_ff, .port5PinIn,
    .port5PinOut_ff, .port5PinOeN_ff, .gpio5Drive, .gpio5In_ff, .altSrc,
    .altIn_ff);
  pad_model u_pad_model (.p4Out(port4PinOut_ff), .p4OeN(port4PinOeN_ff),
    .p5Out(port5PinOut_ff), .p5OeN(port5PinOeN_ff), .p4Board(p4Board),
    .p5Board(p5Board), .p4Level(port4PinIn), .p5Level(port5PinIn));

  // ==========================================================
  // clock and hang guard
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ==========================================================
  // bus and compare helpers; each bus task starts on a rising edge
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask : cmpWord
  task automatic cmpPin(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: pin %b want %b", $time, got, exp);
    end
  endtask : cmpPin
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge sys_clk);
    regReq <= '0;
  endtask : wr
  // read data stand one cycle only, so they are judged mid-cycle
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regReq <= '{addr: a, wrData: 32'h0, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge sys_clk);
    regReq <= '0;
    @(negedge sys_clk);
    cmpWord(rdData_ff, exp);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : tick

  // ==========================================================
  // scenarios
  task automatic test_reset_values();
    rd(A_OUT, 32'h0);
    rd(A_SEL, 32'h0);
    rd(32'hfff83060, 32'h0);
    cmpPin(port4PinOeN_ff, 1'b1);
    $display("test_reset_values done");
  endtask : test_reset_values
  task automatic test_port4();
    wr(A_OUT, 32'hffffffff);
    p4Board <= 1'b1;
    rd(A_OUT, 32'h00000400);
    tick(3);
    rd(A_IN, 32'h00000400);
    wr(A_DIR, 32'h00000400);
    tick(2);
    cmpPin(port4PinOeN_ff, 1'b1);
    wr(A_CFG, 32'h0);
    wr(A_OUT, 32'h0);
    tick(4);
    cmpPin(port4PinOeN_ff, 1'b0);
    cmpPin(port4PinOut_ff, 1'b0);
    rd(A_IN, 32'h0);
    wr(A_OUT, 32'h00000400);
    tick(2);
    cmpPin(port4PinOut_ff, 1'b1);
    wr(A_CFG, 32'h00100000);
    tick(2);
    cmpPin(port4PinOeN_ff, 1'b1);
    $display("test_port4 done");
  endtask : test_port4
  // every code of every pin, reserved ones too, to see them float
  task automatic test_port5_select();
    byte k;
    logic [25:0] sel;
    @(posedge sys_clk);
    gpio5Drive <= '{out: GPIO_OUT, outEn: 13'h1fff};
    altSrc <= '{level: '1, drive: '1};
    for (int p = 0; p < 13; p++)
      for (int c = 0; c < 4; c++)
      begin
        sel = 26'h0;
        sel[2*p+:2] = c[1:0];
        wr(A_SEL, {6'h0, sel});
        rd(A_SEL, {6'h0, sel});
        tick(3);
        k = c == 0 ? "G" : KIND[4*p+c-1];
        if (c == 0)
        begin
          cmpPin(port5PinOeN_ff[p], 1'b0);
          cmpPin(port5PinOut_ff[p], GPIO_OUT[p]);
        end
        else
        begin
          cmpPin(port5PinOeN_ff[p], k != "O");
          if (k == "O") cmpPin(port5PinOut_ff[p], 1'b1);
          cmpPin(altIn_ff[p][c], k != "I");
        end
      end
    $display("test_port5_select done");
  endtask : test_port5_select
  task automatic test_pin6_bidir();
    wr(A_SEL, 32'h00001000);
    altSrc.drive[6][1] <= 1'b0;
    // pad floats one edge after the write, then three edges to altIn
    tick(4);
    cmpPin(port5PinOeN_ff[6], 1'b1);
    cmpPin(altIn_ff[6][1], 1'b0);
    @(posedge sys_clk);
    p5Board[6] <= 1'b1;
    tick(4);
    cmpPin(altIn_ff[6][1], 1'b1);
    cmpPin(gpio5In_ff[6], 1'b1);
    $display("test_pin6_bidir done");
  endtask : test_pin6_bidir

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    test_reset_values();
    test_port4();
    test_port5_select();
    test_pin6_bidir();
    conclude();
  end
endmodule : testbench
